// ---- rtl/ipe_pkg.sv ----
// package for the interrupt priority and enable register block
package ipe_pkg;
   // register byte offsets (chosen, one aligned word each)
   localparam logic [7:0] IPE_OFS_ADC_EN7 = 8'h00;
   localparam logic [7:0] IPE_OFS_PRIO0 = 8'h04;
   localparam logic [7:0] IPE_OFS_PRIO1 = 8'h08;
   localparam logic [7:0] IPE_OFS_PRIO2 = 8'h0C;
   localparam logic [7:0] IPE_OFS_PRIO3 = 8'h10;
   localparam logic [7:0] IPE_OFS_PRIO4 = 8'h14;
   localparam logic [7:0] IPE_OFS_PEND = 8'h18;
   localparam logic [7:0] IPE_OFS_MASK = 8'h1C;
   localparam logic [7:0] IPE_OFS_FWD = 8'h20;
   // enable bit positions
   localparam int IPE_POS_P6 = 4;
   localparam int IPE_POS_P3 = 1;
   localparam int IPE_POS_P2 = 0;
   // priority field low bit positions
   localparam int IPE_POS_F3 = 12;
   localparam int IPE_POS_F2 = 8;
   localparam int IPE_POS_F1 = 4;
   localparam int IPE_POS_F0 = 0;
   // reset values
   localparam logic [2:0] IPE_PRIO_RST = 3'h4;
   localparam logic [2:0] IPE_PRIO_OFF = 3'h0;
   localparam logic [15:0] IPE_EN_RST = 16'h0000;
   // writable masks of the full variant
   localparam logic [15:0] IPE_WM_EN7 = 16'h0013;
   localparam logic [15:0] IPE_WM_P0 = 16'h7777;
   localparam logic [15:0] IPE_WM_P1 = 16'h7000;
   localparam logic [15:0] IPE_WM_P2 = 16'h7770;
   localparam logic [15:0] IPE_WM_P3 = 16'h0077;
   localparam logic [15:0] IPE_WM_P4 = 16'h7777;
   // source count and indices
   localparam int IPE_NSRC = 16;
   localparam int IPE_SRC_EXT0 = 0;
   localparam int IPE_SRC_INCAP = 1;
   localparam int IPE_SRC_OUTCMP = 2;
   localparam int IPE_SRC_TMRA = 3;
   localparam int IPE_SRC_TMRB = 4;
   localparam int IPE_SRC_SPIERR = 5;
   localparam int IPE_SRC_SPIEV = 6;
   localparam int IPE_SRC_SRX = 7;
   localparam int IPE_SRC_STX = 8;
   localparam int IPE_SRC_ADC = 9;
   localparam int IPE_SRC_I2CS = 10;
   localparam int IPE_SRC_I2CM = 11;
   localparam int IPE_SRC_CMPA = 12;
   localparam int IPE_SRC_PCHG = 13;
   localparam int IPE_SRC_ADCP2 = 14;
   localparam int IPE_SRC_ADCP3 = 15;
   // bus transfer states
   typedef enum logic [0:0] {
      IPE_IDLE = 1'b0,
      IPE_ACK = 1'b1
   } ipe_bus_type;
endpackage

// ---- rtl/ipe_regmem.sv ----
// small register memory with masked writes and registered read data
`timescale 1ns/1ps
`default_nettype none
module ipe_regmem #(
   parameter int DEPTH = 6,
   parameter int AW = 3
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic ce,
   // reset image and write mask per word
   input wire logic [DEPTH*16-1:0] rst_val,
   input wire logic [DEPTH*16-1:0] wr_mask,
   // access
   input wire logic wr_en,
   input wire logic [AW-1:0] addr,
   input wire logic [15:0] wr_data,
   output logic [15:0] rd_data,
   // whole contents for the priority logic
   output logic [DEPTH*16-1:0] words
);
   typedef struct packed {
      logic [DEPTH*16-1:0] mem;
      logic [15:0] rd;
      logic init;
   } ipe_mem_type;
   ipe_mem_type st_reg, st_next;
   logic [15:0] m;
   assign words = st_reg.mem;
   assign rd_data = st_reg.rd;
   // masked write keeps unimplemented bits at zero
   always_comb begin
      st_next = st_reg;
      m = wr_mask[addr*16 +: 16];
      if (!st_reg.init) begin
         st_next.mem = rst_val & wr_mask;
         st_next.init = 1'b1;
      end else if (wr_en && (int'(addr) < DEPTH)) begin
         st_next.mem[addr*16 +: 16] = wr_data & m;
      end
      st_next.rd = (int'(addr) < DEPTH) ? st_reg.mem[addr*16 +: 16] : 16'h0000;
   end
   // reset loads constants; the init cycle copies the reset image
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end
endmodule // ipe_regmem
`default_nettype wire

// ---- rtl/ipe_top.sv ----
// interrupt priority and enable registers with APB slave and forwarding
// How it works
// R1: field 111 is level 7, highest
// R2: field 000 disables its source entirely; here it only blocks forwarding, its pending bit still sets and can raise irq
// R3: 001 is level 1, codes linear
// R4: priority fields reset to 100
// R5: unimplemented bits read zero, ignore writes
// R6: enable bit gates request, resets zero
// R7: enable bit 4 is adc pair 6
// R8: enable bit 1 is adc pair 3
// R9: enable bit 0 is adc pair 2
// R10: priority 0 holds four fields
// R11: priority 1 holds timer b only
// R12: priority 2 holds serial rx, spi
// R13: priority 3 holds adc, serial tx
// R14: priority 4 holds change, comparator, i2c
// R15: variant parameters remove absent fields
// R16: highest nonzero enabled pending source forwarded
`timescale 1ns/1ps
`default_nettype none
module ipe_top #(
   parameter logic [15:0] VAR_EN7 = 16'hFFFF,
   parameter logic [15:0] VAR_P0 = 16'hFFFF,
   parameter logic [15:0] VAR_P1 = 16'hFFFF,
   parameter logic [15:0] VAR_P2 = 16'hFFFF,
   parameter logic [15:0] VAR_P3 = 16'hFFFF,
   parameter logic [15:0] VAR_P4 = 16'hFFFF
) (
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clk_en,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // peripheral request levels
   input wire logic [ipe_pkg::IPE_NSRC-1:0] src_req,
   // forwarded request toward the core
   output logic fwd_valid,
   output logic [3:0] fwd_src,
   output logic [2:0] fwd_level,
   output logic irq
);
   import ipe_pkg::*;

   typedef struct packed {
      ipe_bus_type bus;
      logic [31:0] rdata;
      logic slverr;
      logic rd_mem;
      logic rd_pend;
      logic [15:0] pend;
      logic [15:0] mask;
      logic fv;
      logic [3:0] fs;
      logic [2:0] fl;
      logic irq;
   } ipe_state_type;

   ipe_state_type st_reg, st_next;
   logic rst_n;
   logic [95:0] words;
   logic [15:0] mem_rd;
   logic mem_wr;
   logic [2:0] mem_addr;
   logic [95:0] wmask;
   logic [95:0] rimg;
   logic [2:0] prio [IPE_NSRC];
   logic [15:0] en_bit;
   logic hit_mem, hit_pend, hit_mask, hit_fwd, access;
   logic [2:0] best_l;
   logic [3:0] best_s;
   logic [15:0] evt;
   // reset release stages, kept apart since they run on the raw reset
   logic [1:0] rsync_reg;
   // bus answer flops feeding the ports directly
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;

   // field reset image for one priority word [R4]
   function automatic logic [15:0] prio_img(input logic [15:0] wm);
      prio_img = {1'b0, IPE_PRIO_RST, 1'b0, IPE_PRIO_RST, 1'b0, IPE_PRIO_RST, 1'b0, IPE_PRIO_RST} & wm;
   endfunction

   // extract a three-bit field from a stored word
   function automatic logic [2:0] fld(input logic [15:0] w, input int pos);
      fld = w[pos +: 3];
   endfunction

   // two-stage reset release
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rsync_reg <= 2'b00;
      end else begin
         rsync_reg <= {rsync_reg[0], 1'b1};
      end
   end
   assign rst_n = rsync_reg[1];

   // writable masks combine layout and variant [R5] [R15]
   assign wmask = {IPE_WM_P4 & VAR_P4, IPE_WM_P3 & VAR_P3, IPE_WM_P2 & VAR_P2,
                   IPE_WM_P1 & VAR_P1, IPE_WM_P0 & VAR_P0, IPE_WM_EN7 & VAR_EN7};
   // enables reset to zero, priorities to level 4 [R4] [R6]
   assign rimg = {prio_img(wmask[95:80]), prio_img(wmask[79:64]), prio_img(wmask[63:48]),
                  prio_img(wmask[47:32]), prio_img(wmask[31:16]), IPE_EN_RST};

   // address decode
   // the answer cycle still shows psel and penable; it must not start a second transfer
   assign access = psel && penable && (st_reg.bus == IPE_IDLE) && !pready_reg;
   assign hit_mem = (paddr[1:0] == 2'b00) && (paddr < IPE_OFS_PEND);
   assign hit_pend = (paddr == IPE_OFS_PEND);
   assign hit_mask = (paddr == IPE_OFS_MASK);
   assign hit_fwd = (paddr == IPE_OFS_FWD);
   assign mem_addr = paddr[4:2];
   assign mem_wr = access && pwrite && hit_mem;

   ipe_regmem #(.DEPTH(6), .AW(3)) u_mem (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(clk_en),
      .rst_val(rimg),
      .wr_mask(wmask),
      .wr_en(mem_wr),
      .addr(mem_addr),
      .wr_data(pwdata[15:0]),
      .rd_data(mem_rd),
      .words(words)
   );

   // per-source priority fields [R10] [R11] [R12] [R13] [R14]
   always_comb begin
      prio[IPE_SRC_EXT0] = fld(words[31:16], IPE_POS_F0);
      prio[IPE_SRC_INCAP] = fld(words[31:16], IPE_POS_F1);
      prio[IPE_SRC_OUTCMP] = fld(words[31:16], IPE_POS_F2);
      prio[IPE_SRC_TMRA] = fld(words[31:16], IPE_POS_F3);
      prio[IPE_SRC_TMRB] = fld(words[47:32], IPE_POS_F3);
      prio[IPE_SRC_SPIERR] = fld(words[63:48], IPE_POS_F1);
      prio[IPE_SRC_SPIEV] = fld(words[63:48], IPE_POS_F2);
      prio[IPE_SRC_SRX] = fld(words[63:48], IPE_POS_F3);
      prio[IPE_SRC_STX] = fld(words[79:64], IPE_POS_F0);
      prio[IPE_SRC_ADC] = fld(words[79:64], IPE_POS_F1);
      prio[IPE_SRC_I2CS] = fld(words[95:80], IPE_POS_F0);
      prio[IPE_SRC_I2CM] = fld(words[95:80], IPE_POS_F1);
      prio[IPE_SRC_CMPA] = fld(words[95:80], IPE_POS_F2);
      prio[IPE_SRC_PCHG] = fld(words[95:80], IPE_POS_F3);
      // adc pair sources share the adc complete level
      prio[IPE_SRC_ADCP2] = fld(words[79:64], IPE_POS_F1);
      prio[IPE_SRC_ADCP3] = fld(words[79:64], IPE_POS_F1);
   end

   // enable gating: only pair sources have enables in this register
   always_comb begin
      en_bit = 16'h3FFF;
      en_bit[IPE_SRC_ADCP2] = words[IPE_POS_P2]; // [R9] [R6]
      en_bit[IPE_SRC_ADCP3] = words[IPE_POS_P3]; // [R8] [R6]
   end

   // highest nonzero level wins, lowest index breaks ties [R16]
   always_comb begin
      best_l = IPE_PRIO_OFF;
      best_s = 4'h0;
      for (int i = 0; i < IPE_NSRC; i++) begin
         // level 000 never requests; 001..111 ordered as numbers [R1] [R2] [R3]
         if (src_req[i] && en_bit[i] && (prio[i] != IPE_PRIO_OFF) && (prio[i] > best_l)) begin
            best_l = prio[i];
            best_s = 4'(i);
         end
      end
   end

   // sticky events: pair 6 enable gates the adc pair 2 request into event bit 4 of status
   assign evt = (src_req & en_bit) | {11'h000, src_req[IPE_SRC_ADCP2] & words[IPE_POS_P6], 4'h0}; // [R7]

   // bus, status and forwarding
   always_comb begin
      st_next = st_reg;
      st_next.rd_mem = 1'b0;
      st_next.rd_pend = 1'b0;
      // sticky set wins over read clear
      st_next.pend = st_reg.pend | evt;
      if (st_reg.bus == IPE_ACK) begin
         st_next.bus = IPE_IDLE;
         if (st_reg.rd_mem) begin
            st_next.rdata = {16'h0000, mem_rd}; // [R5]
         end
      end else if (access) begin
         st_next.bus = IPE_ACK;
         st_next.slverr = !(hit_mem || hit_pend || hit_mask || hit_fwd);
         st_next.rdata = 32'h0000_0000;
         if (pwrite) begin
            if (hit_mask) begin
               st_next.mask = pwdata[15:0];
            end
         end else if (hit_mem) begin
            st_next.rd_mem = 1'b1;
         end else if (hit_pend) begin
            st_next.rdata = {16'h0000, st_reg.pend};
            st_next.pend = evt;
         end else if (hit_mask) begin
            st_next.rdata = {16'h0000, st_reg.mask};
         end else if (hit_fwd) begin
            st_next.rdata = {24'h000000, st_reg.fv, st_reg.fl, st_reg.fs};
         end
      end
      st_next.fv = (best_l != IPE_PRIO_OFF); // [R2] [R16]
      st_next.fs = best_s;
      st_next.fl = best_l;
      st_next.irq = |(st_next.pend & st_next.mask);
   end

   // state register, frozen while clk_en is low
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.bus <= IPE_IDLE;
         st_reg.rdata <= 32'h0000_0000;
         st_reg.slverr <= 1'b0;
         st_reg.rd_mem <= 1'b0;
         st_reg.rd_pend <= 1'b0;
         st_reg.pend <= 16'h0000;
         st_reg.mask <= 16'h0000;
         st_reg.fv <= 1'b0;
         st_reg.fs <= 4'h0;
         st_reg.fl <= 3'h0;
         st_reg.irq <= 1'b0;
      end else if (clk_en) begin
         st_reg.bus <= st_next.bus;
         st_reg.rdata <= st_next.rdata;
         st_reg.slverr <= st_next.slverr;
         st_reg.rd_mem <= st_next.rd_mem;
         st_reg.rd_pend <= st_next.rd_pend;
         st_reg.pend <= st_next.pend;
         st_reg.mask <= st_next.mask;
         st_reg.fv <= st_next.fv;
         st_reg.fs <= st_next.fs;
         st_reg.fl <= st_next.fl;
         st_reg.irq <= st_next.irq;
      end
   end

   // outputs from flip-flops; read data of memory lands one cycle later
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else if (clk_en) begin
         pready_reg <= (st_reg.bus == IPE_ACK);
         pslverr_reg <= (st_reg.bus == IPE_ACK) && st_reg.slverr;
         prdata_reg <= (st_reg.bus == IPE_ACK) ? st_next.rdata : 32'h0000_0000;
      end
   end
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign fwd_valid = st_reg.fv;
   assign fwd_src = st_reg.fs;
   assign fwd_level = st_reg.fl;
   assign irq = st_reg.irq;
endmodule // ipe_top
`default_nettype wire

// ---- sim/ipe_periph.sv ----
// requesting peripherals: level requests toward the priority block
`timescale 1ns/1ps
`default_nettype none
module ipe_periph (
   // clock
   input wire logic clk_sys,
   // levels the bench wants raised
   input wire logic [15:0] want,
   // level requests
   output logic [15:0] src_req
);
   // requests move only just after a rising edge, as on-chip logic does
   always_ff @(posedge clk_sys) begin
      src_req <= want;
   end
endmodule // ipe_periph
`default_nettype wire

// ---- sim/ipe_top_chk.sv ----
// concurrent checks on the bus and forwarding ports
`timescale 1ns/1ps
`default_nettype none
module ipe_chk (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic clk_en,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // requests and forwarding
   input wire logic [ipe_pkg::IPE_NSRC-1:0] src_req,
   input wire logic fwd_valid,
   input wire logic [3:0] fwd_src,
   input wire logic [2:0] fwd_level,
   input wire logic irq
);
   logic [15:0] req_d;
   // requests one edge ago, matching the forwarding lag
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         req_d <= 16'h0000;
      end else begin
         req_d <= src_req;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   ack_delay_a: assert property (psel && $rose(penable) |-> !pready ##1 !pready ##1 pready)
      else $error("answer not two edges after access");
   ack_single_a: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   ack_select_a: assert property (pready |-> psel && penable)
      else $error("ready without access");
   unmapped_err_a: assert property (pready && paddr > 8'h20 |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   enable_gaps_a: assert property (pready && !pwrite && paddr == 8'h00 |-> (prdata[15:0] & 16'hFFEC) == 16'h0)
      else $error("enable gap bits set");
   prio_gaps_a: assert property (pready && !pwrite && paddr == 8'h08 |-> (prdata[15:0] & 16'h8FFF) == 16'h0)
      else $error("priority one gap bits set");
   fwd_level_a: assert property (fwd_valid |-> fwd_level != 3'h0)
      else $error("forwarded level zero");
   fwd_idle_a: assert property (src_req == 16'h0 |=> !fwd_valid)
      else $error("forward with no request");
   fwd_source_a: assert property (fwd_valid |-> req_d[fwd_src])
      else $error("forwarded source not requesting");
endmodule // ipe_chk
bind ipe_top ipe_chk u_chk (.clk_sys, .rstn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .src_req, .fwd_valid, .fwd_src, .fwd_level, .irq);
`default_nettype wire

// ---- sim/ipe_top_tb.sv ----
// self-checking bench for the priority and enable register block
`timescale 1ns/1ps
`default_nettype none
module ipe_top_tb;
   import ipe_pkg::*;
   logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr, fwd_valid, irq, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] want, src_req;
   logic [3:0] fwd_src;
   logic [2:0] fwd_level;
   int errors, cmp_count, cycles;
   logic [7:0] ofs [6] = '{IPE_OFS_ADC_EN7, IPE_OFS_PRIO0, IPE_OFS_PRIO1, IPE_OFS_PRIO2, IPE_OFS_PRIO3, IPE_OFS_PRIO4};
   logic [15:0] rstv [6] = '{16'h0000, 16'h4444, 16'h4000, 16'h4440, 16'h0044, 16'h4444};
   logic [15:0] wm [6] = '{16'h0013, 16'h7777, 16'h7000, 16'h7770, 16'h0077, 16'h7777};
   ipe_top uut (.clk_sys, .rstn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .src_req, .fwd_valid, .fwd_src, .fwd_level, .irq);
   ipe_periph pm (.clk_sys, .want, .src_req);
   // 100 ns clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // cycle ceiling against a hang
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      cmp_count++;
      if (g !== x) begin
         $display("BAD %s expected %h seen %h", nm, x, g);
         errors++;
      end
   endtask
   // one apb transfer; held until ready is sampled high
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      // ends once ready is sampled high; if ready never rises, only the bench ceiling ends this wait
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      bus(1'b0, a, 16'h0000);
      chk("rdata", x, q);
   endtask
   // settle requests, then compare {valid, level, source}
   task automatic fwd(input logic [15:0] w, input logic [7:0] x);
      want <= w;
      repeat (3) @(posedge clk_sys);
      chk("fwd", {24'h0, x}, {24'h0, fwd_valid, fwd_level, fwd_src});
   endtask
   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata, want} = '0;
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      // reset image, then writable bits and write-back of zeros
      foreach (ofs[i]) rd(ofs[i], {16'h0, rstv[i]});
      foreach (ofs[i]) begin
         bus(1'b1, ofs[i], 16'hFFFF);
         rd(ofs[i], {16'h0, wm[i]});
         bus(1'b1, ofs[i], 16'h0000);
         rd(ofs[i], 32'h0);
      end
      bus(1'b1, 8'h24, 16'hFFFF);
      rd(8'h24, 32'h0);
      chk("slverr", 32'h1, {31'h0, e});
      // every timer code against an ext0 source at level one
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, IPE_OFS_PRIO0, 16'(c << 12) | 16'h0001);
         fwd(16'h0008, c == 0 ? 8'h00 : {1'b1, 3'(c), 4'h3});
         fwd(16'h0009, c > 1 ? {1'b1, 3'(c), 4'h3} : 8'h90);
      end
      // adc pair requests gated by their enable bits
      bus(1'b1, IPE_OFS_PRIO3, 16'h0040);
      for (int j = 0; j < 2; j++) begin
         bus(1'b1, IPE_OFS_ADC_EN7, 16'h0000);
         fwd(16'h4000 << j, 8'h00);
         bus(1'b1, IPE_OFS_ADC_EN7, 16'h0001 << j);
         fwd(16'h4000 << j, {4'hC, 4'(14 + j)});
      end
      // interrupt: masked event, unmask, clear by read
      fwd(16'h0000, 8'h00);
      bus(1'b1, IPE_OFS_MASK, 16'h0000);
      bus(1'b0, IPE_OFS_PEND, 16'h0000);
      fwd(16'h0008, 8'hF3);
      rd(IPE_OFS_FWD, 32'h0000_00F3);
      fwd(16'h0000, 8'h00);
      chk("irq", 32'h0, {31'h0, irq});
      bus(1'b1, IPE_OFS_MASK, 16'hFFFF);
      rd(IPE_OFS_MASK, 32'h0000_FFFF);
      repeat (2) @(posedge clk_sys);
      chk("irq", 32'h1, {31'h0, irq});
      rd(IPE_OFS_PEND, 32'h0000_0008);
      repeat (2) @(posedge clk_sys);
      chk("irq", 32'h0, {31'h0, irq});
      rd(IPE_OFS_PEND, 32'h0);
      stop_test();
   end
endmodule // ipe_top_tb
`default_nettype wire
